//--- hdl/software_standby_controller.sv
// Power-down sequencer for ordinary sleep and software standby, with
// the wake paths by interrupt, hard-init pin and deep-halt pin.
// Assumes all pins are synchronous to REF_CLK; the CPU pulses SLEEP_EXEC
// once per sleep instruction and PCLK_TICK marks peripheral clock cycles.
`timescale 1ns/1ps

// Behaviour
// - Sleep with standby_select set enters standby
// - Sleep with standby_select clear enters sleep
// - Standby stops CPU, peripherals and oscillator
// - Standby keeps state, serial unit is reset
// - bus_output_hold chooses hold or high-impedance bus
// - Running watchdog refuses standby entry
// - Interrupt wake: oscillator, settle, then exception
// - Line wakes standby only with wake and enable set
// - Masked or transfer-controller sources never wake
// - Init pin low restarts clocks without settling
// - Init pin high starts reset exception
// - Deep-halt pin low enters hardware standby
// - Settle code selects 64 to 524288 cycles
// - nmi_edge_sel picks falling or rising edge
module software_standby_controller #(
  parameter int IRQ_LINES = 12,
  parameter int SETTLE_SHIFT = 0
) (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic SLEEP_EXEC,
  input wire logic WATCHDOG_RUN,
  input wire logic CPU_IRQ_MASK,
  input wire logic PCLK_TICK,
  input wire logic NMI_PIN,
  input wire logic [IRQ_LINES-1:0] EXT_IRQ_LINES_N,
  input wire logic HARD_INIT_PIN_N,
  input wire logic DEEP_HALT_PIN_N,
  output logic CPU_CLK_EN,
  output logic PERIPH_CLK_EN,
  output logic OSC_EN,
  output logic SERIAL_COMM_UNIT_RST,
  output logic BUS_HIZ,
  output logic STATE_RETAIN,
  output logic WAKE_IRQ_EXC,
  output logic RESET_EXC,
  output logic [2:0] PM_STATE
);
  import standby_pkg::*;

  pm_state_t state_q, state_d;
  logic standby_select_q;
  logic bus_output_hold_q;
  logic [SETTLE_SEL_W-1:0] settle_time_sel_q;
  logic nmi_edge_sel_q;
  logic [IRQ_LINES-1:0] irq_wake_en_q;
  logic [IRQ_LINES-1:0] irq_en_q;
  logic [IRQ_LINES-1:0] dtc_source_q;
  logic refused_q;
  logic nmi_q;
  logic [SETTLE_CNT_W-1:0] settle_cnt_q;
  logic [SETTLE_CNT_W-1:0] settle_load;
  logic [IRQ_LINES-1:0] irq_wake_line;
  logic nmi_edge;
  logic irq_wake;
  logic irq_any;
  logic wake_req;
  logic settle_done;
  logic wb_req;
  logic wb_wr;
  logic refuse_evt;

  // Bus slave: one wait state, ack drops in the cycle after it was given
  assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wb_wr = wb_req & WB_WE_I;

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      WB_ACK_O <= 1'b0;
    end else if (CE) begin
      WB_ACK_O <= wb_req;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (CE && wb_req) begin
      WB_DAT_O <= 32'h0000_0000;
      unique case (WB_ADR_I)
        STANDBY_CONTROL_REG_OFS: begin
          WB_DAT_O[STANDBY_SELECT_BIT] <= standby_select_q;
          WB_DAT_O[BUS_OUTPUT_HOLD_BIT] <= bus_output_hold_q;
          WB_DAT_O[SETTLE_SEL_LSB +: SETTLE_SEL_W] <= settle_time_sel_q;
        end
        IRQ_WAKE_ENABLE_REG_OFS: WB_DAT_O[IRQ_LINES-1:0] <= irq_wake_en_q;
        INT_EDGE_CTRL_REG_OFS: WB_DAT_O[NMI_EDGE_SEL_BIT] <= nmi_edge_sel_q;
        IRQ_ENABLE_REG_OFS: WB_DAT_O[IRQ_LINES-1:0] <= irq_en_q;
        DTC_SOURCE_REG_OFS: WB_DAT_O[IRQ_LINES-1:0] <= dtc_source_q;
        STATUS_REG_OFS: begin
          WB_DAT_O[STATE_W-1:0] <= state_q;
          WB_DAT_O[STATUS_REFUSED_BIT] <= refused_q;
        end
        default: WB_DAT_O <= 32'h0000_0000;
      endcase
    end
  end

  // Control bits live in byte lane 1
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      standby_select_q <= STANDBY_SELECT_RST;
      bus_output_hold_q <= BUS_OUTPUT_HOLD_RST;
      settle_time_sel_q <= SETTLE_SEL_RST;
    end else if (CE && wb_wr && WB_SEL_I[1] && WB_ADR_I == STANDBY_CONTROL_REG_OFS) begin
      standby_select_q <= WB_DAT_I[STANDBY_SELECT_BIT];
      bus_output_hold_q <= WB_DAT_I[BUS_OUTPUT_HOLD_BIT];
      settle_time_sel_q <= WB_DAT_I[SETTLE_SEL_LSB +: SETTLE_SEL_W];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      nmi_edge_sel_q <= NMI_EDGE_SEL_RST;
    end else if (CE && wb_wr && WB_SEL_I[1] && WB_ADR_I == INT_EDGE_CTRL_REG_OFS) begin
      nmi_edge_sel_q <= WB_DAT_I[NMI_EDGE_SEL_BIT];
    end
  end

  // Per-line mask registers, written lane by lane
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_LINES; gi++) begin : g_line
      always_ff @(posedge REF_CLK) begin
        if (SRST) begin
          irq_wake_en_q[gi] <= 1'b0;
          irq_en_q[gi] <= 1'b0;
          dtc_source_q[gi] <= 1'b0;
        end else if (CE && wb_wr && WB_SEL_I[gi/8]) begin
          if (WB_ADR_I == IRQ_WAKE_ENABLE_REG_OFS) begin
            irq_wake_en_q[gi] <= WB_DAT_I[gi];
          end
          if (WB_ADR_I == IRQ_ENABLE_REG_OFS) begin
            irq_en_q[gi] <= WB_DAT_I[gi];
          end
          if (WB_ADR_I == DTC_SOURCE_REG_OFS) begin
            dtc_source_q[gi] <= WB_DAT_I[gi];
          end
        end
      end
      // Line wakes only when wake-enabled, enabled, unmasked and not a DATA_TRANSFER_CONTROLLER source
      assign irq_wake_line[gi] = ~EXT_IRQ_LINES_N[gi] & irq_wake_en_q[gi] & irq_en_q[gi]
                                 & ~dtc_source_q[gi];
    end
  endgenerate

  // Ordinary sleep wakes on any enabled, unmasked line that is not a DTC source, wake enable not needed
  assign irq_any = ~CPU_IRQ_MASK & |(~EXT_IRQ_LINES_N & irq_en_q & ~dtc_source_q);
  assign irq_wake = ~CPU_IRQ_MASK & |irq_wake_line;

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      // Seeded from the pin so that leaving reset never shows a false edge
      nmi_q <= NMI_PIN;
    end else if (CE) begin
      nmi_q <= NMI_PIN;
    end
  end

  // Selected edge serves both sleep wake and standby wake
  assign nmi_edge = nmi_edge_sel_q ? (NMI_PIN & ~nmi_q) : (~NMI_PIN & nmi_q);
  assign wake_req = nmi_edge | irq_wake;

  // Reserved codes fall back to the longest wait, the safe side for a crystal
  always_comb begin
    settle_load = SETTLE_524288;
    unique case (settle_time_sel_q)
      5'h05: settle_load = SETTLE_64;
      5'h06: settle_load = SETTLE_512;
      5'h07: settle_load = SETTLE_1024;
      5'h08: settle_load = SETTLE_2048;
      5'h09: settle_load = SETTLE_4096;
      5'h0a: settle_load = SETTLE_16384;
      5'h0b: settle_load = SETTLE_32768;
      5'h0c: settle_load = SETTLE_65536;
      5'h0d: settle_load = SETTLE_131072;
      5'h0e: settle_load = SETTLE_262144;
      default: settle_load = SETTLE_524288;
    endcase
    settle_load = settle_load >> SETTLE_SHIFT;
    if (settle_load == '0) begin
      settle_load = {{(SETTLE_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  assign settle_done = PCLK_TICK && settle_cnt_q == {{(SETTLE_CNT_W-1){1'b0}}, 1'b1};

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      settle_cnt_q <= '0;
    end else if (CE) begin
      if (state_q == ST_STANDBY && wake_req) begin
        settle_cnt_q <= settle_load;
      end else if (state_q == ST_SETTLE && PCLK_TICK) begin
        settle_cnt_q <= settle_cnt_q - {{(SETTLE_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign refuse_evt = state_q == ST_RUN && SLEEP_EXEC && standby_select_q && WATCHDOG_RUN;

  // Sticky: a new refusal wins over a write-one clear in the same cycle
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      refused_q <= 1'b0;
    end else if (CE) begin
      if (refuse_evt) begin
        refused_q <= 1'b1;
      end else if (wb_wr && WB_SEL_I[1] && WB_ADR_I == STATUS_REG_OFS && WB_DAT_I[STATUS_REFUSED_BIT]) begin
        refused_q <= 1'b0;
      end
    end
  end

  // Deep-halt pin has top priority from every state
  always_comb begin
    state_d = state_q;
    if (!DEEP_HALT_PIN_N) begin
      state_d = ST_HW_STANDBY;
    end else begin
      unique case (state_q)
        ST_RUN: begin
          if (SLEEP_EXEC) begin
            state_d = (standby_select_q && !WATCHDOG_RUN) ? ST_STANDBY : ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (!HARD_INIT_PIN_N) begin
            state_d = ST_RESET_HOLD;
          end else if (nmi_edge || irq_any) begin
            state_d = ST_RUN;
          end
        end
        ST_STANDBY: begin
          if (!HARD_INIT_PIN_N) begin
            state_d = ST_RESET_HOLD;
          end else if (wake_req) begin
            state_d = ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (!HARD_INIT_PIN_N) begin
            state_d = ST_RESET_HOLD;
          end else if (settle_done) begin
            state_d = ST_RUN;
          end
        end
        ST_RESET_HOLD: begin
          if (HARD_INIT_PIN_N) begin
            state_d = ST_RUN;
          end
        end
        ST_HW_STANDBY: state_d = ST_RESET_HOLD;
        default: state_d = ST_RUN;
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      state_q <= ST_RUN;
    end else if (CE) begin
      state_q <= state_d;
    end
  end

  // Outputs registered from the next state so all clocks switch on one edge
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      CPU_CLK_EN <= 1'b1;
      PERIPH_CLK_EN <= 1'b1;
      OSC_EN <= 1'b1;
      SERIAL_COMM_UNIT_RST <= 1'b0;
      BUS_HIZ <= 1'b0;
      STATE_RETAIN <= 1'b0;
      PM_STATE <= ST_RUN;
    end else if (CE) begin
      CPU_CLK_EN <= state_d == ST_RUN || state_d == ST_RESET_HOLD;
      PERIPH_CLK_EN <= state_d == ST_RUN || state_d == ST_SLEEP || state_d == ST_RESET_HOLD;
      OSC_EN <= state_d != ST_STANDBY && state_d != ST_HW_STANDBY;
      // Serial unit loses its state across standby; everything else holds
      SERIAL_COMM_UNIT_RST <= state_d == ST_STANDBY || state_d == ST_SETTLE;
      STATE_RETAIN <= state_d == ST_STANDBY || state_d == ST_SETTLE;
      BUS_HIZ <= state_d == ST_HW_STANDBY
                 || ((state_d == ST_STANDBY || state_d == ST_SETTLE) && !bus_output_hold_q);
      PM_STATE <= state_d;
    end
  end

  // One-cycle exception requests to the CPU
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      WAKE_IRQ_EXC <= 1'b0;
      RESET_EXC <= 1'b0;
    end else if (CE) begin
      WAKE_IRQ_EXC <= state_d == ST_RUN && (state_q == ST_SETTLE || state_q == ST_SLEEP);
      RESET_EXC <= state_d == ST_RUN && state_q == ST_RESET_HOLD;
    end
  end

endmodule

//--- include/standby_pkg.sv
// Constants for the software standby controller: register map, field layout,
// reset values and the settling-count table.
// Assumes a 32-bit classic Wishbone bus with byte addressing.
package standby_pkg;

  // Register byte offsets
  localparam logic [7:0] STANDBY_CONTROL_REG_OFS = 8'h00;
  localparam logic [7:0] IRQ_WAKE_ENABLE_REG_OFS = 8'h04;
  localparam logic [7:0] INT_EDGE_CTRL_REG_OFS = 8'h08;
  localparam logic [7:0] IRQ_ENABLE_REG_OFS = 8'h0c;
  localparam logic [7:0] DTC_SOURCE_REG_OFS = 8'h10;
  localparam logic [7:0] STATUS_REG_OFS = 8'h14;

  // Field positions
  localparam int STANDBY_SELECT_BIT = 15;
  localparam int BUS_OUTPUT_HOLD_BIT = 14;
  localparam int SETTLE_SEL_LSB = 8;
  localparam int SETTLE_SEL_W = 5;
  localparam int NMI_EDGE_SEL_BIT = 8;
  localparam int STATUS_REFUSED_BIT = 8;
  localparam int STATE_W = 3;

  // Reset values
  localparam logic STANDBY_SELECT_RST = 1'b0;
  localparam logic BUS_OUTPUT_HOLD_RST = 1'b1;
  localparam logic [4:0] SETTLE_SEL_RST = 5'h0f;
  localparam logic NMI_EDGE_SEL_RST = 1'b0;

  // Settling counts in peripheral clock cycles
  localparam int SETTLE_CNT_W = 20;
  localparam logic [19:0] SETTLE_64 = 20'h00040;
  localparam logic [19:0] SETTLE_512 = 20'h00200;
  localparam logic [19:0] SETTLE_1024 = 20'h00400;
  localparam logic [19:0] SETTLE_2048 = 20'h00800;
  localparam logic [19:0] SETTLE_4096 = 20'h01000;
  localparam logic [19:0] SETTLE_16384 = 20'h04000;
  localparam logic [19:0] SETTLE_32768 = 20'h08000;
  localparam logic [19:0] SETTLE_65536 = 20'h10000;
  localparam logic [19:0] SETTLE_131072 = 20'h20000;
  localparam logic [19:0] SETTLE_262144 = 20'h40000;
  localparam logic [19:0] SETTLE_524288 = 20'h80000;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_STANDBY,
    ST_SETTLE,
    ST_RESET_HOLD,
    ST_HW_STANDBY
  } pm_state_t;

endpackage

//--- bench/standby_monitor.sv
// Checker for the standby sequencer, watching the top module's ports only.
// Assumes one clock REF_CLK and a synchronous active-high SRST.
`timescale 1ns/1ps
module standby_monitor
  import standby_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic SLEEP_EXEC,
  input wire logic WATCHDOG_RUN,
  input wire logic HARD_INIT_PIN_N,
  input wire logic DEEP_HALT_PIN_N,
  input wire logic CPU_CLK_EN,
  input wire logic PERIPH_CLK_EN,
  input wire logic OSC_EN,
  input wire logic SERIAL_COMM_UNIT_RST,
  input wire logic STATE_RETAIN,
  input wire logic WAKE_IRQ_EXC,
  input wire logic RESET_EXC,
  input wire logic [2:0] PM_STATE
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  wire logic pins_hi = HARD_INIT_PIN_N && DEEP_HALT_PIN_N;
  sequence sleep_req;
    PM_STATE == ST_RUN && SLEEP_EXEC && CE && pins_hi;
  endsequence
  sequence settle_end;
    PM_STATE == ST_SETTLE ##1 PM_STATE == ST_RUN;
  endsequence
  wdog_refuse_a: assert property (sleep_req ##0 WATCHDOG_RUN |=> PM_STATE == ST_SLEEP)
    else $error("standby entered with watchdog running");
  standby_entry_a: assert property ($rose(PM_STATE == ST_STANDBY) |->
    $past(PM_STATE) == ST_RUN && !$past(WATCHDOG_RUN)) else $error("bad standby entry");
  clocks_stop_a: assert property (PM_STATE == ST_STANDBY |-> !CPU_CLK_EN && !PERIPH_CLK_EN && !OSC_EN)
    else $error("clock running in standby");
  retain_state_a: assert property (PM_STATE inside {ST_STANDBY, ST_SETTLE} |->
    STATE_RETAIN && SERIAL_COMM_UNIT_RST) else $error("state not retained");
  settle_gate_a: assert property (PM_STATE == ST_SETTLE |-> OSC_EN && !CPU_CLK_EN && !PERIPH_CLK_EN)
    else $error("clocks not gated while settling");
  settle_exit_a: assert property (settle_end |-> WAKE_IRQ_EXC && CPU_CLK_EN && PERIPH_CLK_EN)
    else $error("settle exit without clocks and exception");
  init_wake_a: assert property (PM_STATE == ST_STANDBY && !HARD_INIT_PIN_N && DEEP_HALT_PIN_N && CE |=>
    PM_STATE == ST_RESET_HOLD && CPU_CLK_EN && PERIPH_CLK_EN && OSC_EN) else $error("init pin wake wrong");
  reset_exc_a: assert property (PM_STATE == ST_RESET_HOLD && pins_hi && CE |=>
    PM_STATE == ST_RUN && RESET_EXC) else $error("no reset exception");
  halt_entry_a: assert property (PM_STATE == ST_STANDBY && !DEEP_HALT_PIN_N && CE |=>
    PM_STATE == ST_HW_STANDBY) else $error("deep halt not entered");
endmodule

bind software_standby_controller standby_monitor standby_monitor_inst (.REF_CLK(REF_CLK), .SRST(SRST),
  .CE(CE), .SLEEP_EXEC(SLEEP_EXEC), .WATCHDOG_RUN(WATCHDOG_RUN), .HARD_INIT_PIN_N(HARD_INIT_PIN_N),
  .DEEP_HALT_PIN_N(DEEP_HALT_PIN_N), .CPU_CLK_EN(CPU_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN), .OSC_EN(OSC_EN),
  .SERIAL_COMM_UNIT_RST(SERIAL_COMM_UNIT_RST), .STATE_RETAIN(STATE_RETAIN), .WAKE_IRQ_EXC(WAKE_IRQ_EXC),
  .RESET_EXC(RESET_EXC), .PM_STATE(PM_STATE));

//--- bench/init_pin_partner.sv
// Model of the board driving the hard-init pin.
// Assumes the request pulse comes from the bench on REF_CLK.
`timescale 1ns/1ps
module init_pin_partner #(
  parameter int HOLD = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic req,
  input wire logic osc_en,
  output logic init_n
);
  int cnt;
  // Held low past the request until the oscillator has run HOLD+1 cycles
  always_ff @(posedge clk) begin
    if (srst) begin
      init_n <= 1'b1;
      cnt <= 0;
    end else if (req) begin
      init_n <= 1'b0;
      cnt <= 0;
    end else if (!init_n) begin
      cnt <= osc_en ? cnt + 1 : 0;
      if (osc_en && cnt >= HOLD) init_n <= 1'b1;
    end
  end
endmodule

//--- bench/software_standby_controller_tb.sv
// Self-checking bench: Wishbone register access plus pin stimulus.
// Assumes SETTLE_SHIFT 6, so counts are 64/512/524288 divided by 64.
`timescale 1ns/1ps
module software_standby_controller_tb;
  import standby_pkg::*;
  logic clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, sleep = 0, wdog = 0, mask = 0, nmi = 0;
  logic halt_n = 1, init_req = 0, ack, cpu_en, per_en, osc_en, ser_rst, hiz, retain, wexc, rexc, init_n;
  logic ce = 1, tick = 1;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 0;
  logic [31:0] wdat = 0, rdat, q;
  logic [11:0] irq_n = 12'hfff;
  logic [2:0] st;
  logic [4:0] codes [3] = '{5'h05, 5'h06, 5'h00};
  int ticks [3] = '{1, 8, 8192};
  int n_errors = 0, compares = 0, n, k;
  always #2 clk = ~clk;
  software_standby_controller #(.IRQ_LINES(12), .SETTLE_SHIFT(6)) software_standby_controller_inst (
    .REF_CLK(clk), .SRST(srst), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .SLEEP_EXEC(sleep),
    .WATCHDOG_RUN(wdog), .CPU_IRQ_MASK(mask), .PCLK_TICK(tick), .NMI_PIN(nmi), .EXT_IRQ_LINES_N(irq_n),
    .HARD_INIT_PIN_N(init_n), .DEEP_HALT_PIN_N(halt_n), .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(per_en),
    .OSC_EN(osc_en), .SERIAL_COMM_UNIT_RST(ser_rst), .BUS_HIZ(hiz), .STATE_RETAIN(retain),
    .WAKE_IRQ_EXC(wexc), .RESET_EXC(rexc), .PM_STATE(st));
  init_pin_partner #(.HOLD(4)) init_pin_partner_inst (.clk(clk), .srst(srst), .req(init_req),
    .osc_en(osc_en), .init_n(init_n));
  task summarize;
    if (n_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge clk);
    q = rdat;
    cyc <= 0; stb <= 0;
    if (i == 20) begin n_errors++; summarize(); end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  // Bounded wait; n returns the cycles spent before the state showed up
  task wait_st(input logic [2:0] e);
    for (n = 0; n < 20000 && st !== e; n++) @(posedge clk);
    if (n == 20000) begin n_errors++; summarize(); end
  endtask
  task slp;
    @(posedge clk); sleep <= 1;
    @(posedge clk); sleep <= 0;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    srst <= 0;
    rd(STANDBY_CONTROL_REG_OFS, 32'h00004f00, "ctrl reset");
    rd(INT_EDGE_CTRL_REG_OFS, 32'h0, "edge reset");
    rd(8'h1c, 32'h0, "unmapped");
    // Clock enable low must swallow a sleep pulse
    ce <= 0;
    slp;
    repeat (2) @(posedge clk);
    chk("ce freeze", ST_RUN, st);
    ce <= 1;
    bus(1, IRQ_ENABLE_REG_OFS, 32'h00000fff);
    bus(1, STANDBY_CONTROL_REG_OFS, 32'h00000f00);
    slp; wait_st(ST_SLEEP);
    chk("sleep clocks", 2'b01, {cpu_en, per_en});
    irq_n[3] <= 0; wait_st(ST_RUN); irq_n <= 12'hfff;
    bus(1, STANDBY_CONTROL_REG_OFS, 32'h00008f00);
    wdog <= 1; slp; wait_st(ST_SLEEP);
    rd(STATUS_REG_OFS, 32'h00000101, "refused");
    bus(1, STATUS_REG_OFS, 32'h00000100);
    rd(STATUS_REG_OFS, 32'h00000001, "refused clear");
    wdog <= 0; irq_n[0] <= 0; wait_st(ST_RUN); irq_n <= 12'hfff;
    // Each pass refuses one line wake differently, then wakes on the NMI edge
    for (k = 0; k < 3; k++) begin
      nmi <= ~k[0];
      bus(1, INT_EDGE_CTRL_REG_OFS, {23'h0, k[0], 8'h0});
      bus(1, IRQ_WAKE_ENABLE_REG_OFS, k == 0 ? 32'h0 : 32'h2);
      bus(1, DTC_SOURCE_REG_OFS, k == 1 ? 32'h2 : 32'h0);
      mask <= (k == 2);
      bus(1, STANDBY_CONTROL_REG_OFS, {16'h0, 1'b1, k[0], 1'b0, codes[k], 8'h0});
      slp; wait_st(ST_STANDBY);
      chk("standby clocks", 3'b000, {cpu_en, per_en, osc_en});
      chk("bus hiz", !k[0], hiz);
      chk("retain", 2'b11, {retain, ser_rst});
      irq_n[1] <= 0; repeat (6) @(posedge clk);
      chk("refused wake", ST_STANDBY, st);
      nmi <= k[0]; wait_st(ST_SETTLE);
      wait_st(ST_RUN);
      chk("settle count", ticks[k], n);
      chk("wake exc", 1'b1, wexc);
      irq_n <= 12'hfff; mask <= 0;
    end
    // Enabled line wakes standby; with no peripheral tick the wait stays open
    bus(1, STANDBY_CONTROL_REG_OFS, 32'h0000c500);
    slp;
    wait_st(ST_STANDBY);
    tick <= 0;
    irq_n[1] <= 0;
    wait_st(ST_SETTLE);
    repeat (4) @(posedge clk);
    chk("settle hold", ST_SETTLE, st);
    chk("settle gated", 3'b001, {cpu_en, per_en, osc_en});
    tick <= 1;
    wait_st(ST_RUN);
    chk("line wake", 1'b1, wexc);
    irq_n <= 12'hfff;
    bus(1, STANDBY_CONTROL_REG_OFS, 32'h0000c500);
    slp; wait_st(ST_STANDBY);
    init_req <= 1; wait_st(ST_RESET_HOLD);
    chk("init clocks", 3'b111, {cpu_en, per_en, osc_en});
    init_req <= 0; wait_st(ST_RUN);
    chk("reset exc", 1'b1, rexc);
    bus(1, STANDBY_CONTROL_REG_OFS, 32'h0000c500);
    slp; wait_st(ST_STANDBY);
    halt_n <= 0; wait_st(ST_HW_STANDBY);
    chk("deep halt", ST_HW_STANDBY, st);
    halt_n <= 1; wait_st(ST_RUN);
    summarize;
  end
endmodule
